// ---- design/plu_core.v ----
// Behaviour
// R1: Software normalizes raw input as raw over span plus offset 0 or 0.5.
// R2: Default spans are 32000 unipolar and 64000 bipolar counts.
// R3: Software scales output as loop output minus bipolar half offset, times span.
// R4: Software truncates scaled output and writes low 16 bits to the analog channel.
// R5: Positive gain acts forward, negative gain acts reverse.
// R6: With zero gain, the signs of the integral and derivative times set direction.
// R7: Process value and setpoint are only read, except during bumpless initialization.
// R8: Each calculation writes the loop output clamped to zero through one.
// R9: Integral sum updates the stored bias, used by the next calculation.
// R10: Output above one gives bias one minus P plus D; below zero gives minus P plus D.
// R11: Adjusted bias is clamped to zero through one and stored each calculation.
// R12: Software may write bias before a calculation, only within zero through one.
// R13: Previous process value is kept for derivative action; software leaves it alone.
// R14: Calculation runs only with enable high; high is auto, low is manual.
// R15: A history bit holds the previous enable to detect a rising enable.
// R16: Rising enable copies process value to setpoint and previous value, output to bias.
// R17: Software loads the manual output into the output entry before raising enable.
// R18: History bit is set at reset and run entry, so no initialization then.
// R19: Integral term is gain times sample over integral time times error, plus bias.
// R20: Derivative term is gain times rate over sample time times previous minus current value.
// R21: On the first sample the previous process value equals the current one.
// R22: Zero gain is replaced by one for the integral and derivative terms.
// R23: Unclamped output is the sum of the three terms before clamping.
`timescale 1ns/1ps
`include "plu_defines.vh"

module plu_core #(
    parameter W = `PLU_WIDTH
) (
    input  wire                  clock,
    input  wire                  reset,
    input  wire                  run_entry,
    input  wire                  evaluate,
    input  wire                  enable,
    input  wire                  tbl_wr,
    input  wire [`PLU_IDX_W-1:0] tbl_idx,
    input  wire [W-1:0]          tbl_wdata,
    output wire [W-1:0]          process_value,
    output wire [W-1:0]          setpoint,
    output wire [W-1:0]          loop_output,
    output wire [W-1:0]          loop_gain,
    output wire [W-1:0]          sample_period,
    output wire [W-1:0]          reset_period,
    output wire [W-1:0]          rate_period,
    output wire [W-1:0]          bias_sum,
    output wire [W-1:0]          previous_process_value,
    output wire                  history_bit,
    output wire                  busy,
    output wire                  calc_done
);
    // ======================================================================
    // States
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_INIT = 3'h1;
    localparam [2:0] ST_DIVI = 3'h2;
    localparam [2:0] ST_DIVD = 3'h3;
    localparam [2:0] ST_COEF = 3'h4;
    localparam [2:0] ST_TERM = 3'h5;
    localparam [2:0] ST_SUM  = 3'h6;
    // Terms carry headroom bits so the three-way sum cannot wrap
    localparam       TW      = W + 4;

    // ======================================================================
    // Fixed-point helpers
    function [W-1:0] fmul;
        input [W-1:0] a;
        input [W-1:0] b;
        reg signed [2*W-1:0] p;
        begin
            p = $signed(a) * $signed(b);
            if (p[2*W-1] && !(&p[2*W-1:W+`PLU_FRAC-1]))
                fmul = {1'b1, {(W-1){1'b0}}};
            else if (!p[2*W-1] && (|p[2*W-1:W+`PLU_FRAC-1]))
                fmul = {1'b0, {(W-1){1'b1}}};
            else
                fmul = p[W+`PLU_FRAC-1:`PLU_FRAC];
        end
    endfunction

    function [TW-1:0] sext;
        input [W-1:0] a;
        begin
            sext = {{(TW-W){a[W-1]}}, a};
        end
    endfunction

    function [W-1:0] clamp01;
        input [TW-1:0] v;
        begin
            if (v[TW-1])
                clamp01 = `PLU_ZERO;
            else if (v > sext(`PLU_ONE))
                clamp01 = `PLU_ONE;
            else
                clamp01 = v[W-1:0];
        end
    endfunction

    // ======================================================================
    // Loop table and control state
    reg  [W-1:0]  pv_ff;
    reg  [W-1:0]  sp_ff;
    reg  [W-1:0]  out_ff;
    reg  [W-1:0]  gain_ff;
    reg  [W-1:0]  ts_ff;
    reg  [W-1:0]  ti_ff;
    reg  [W-1:0]  td_ff;
    reg  [W-1:0]  bias_ff;
    reg  [W-1:0]  prev_ff;
    reg           hist_ff;
    reg           first_ff;
    reg           bump_ff;
    reg           done_ff;
    // Registered copy of the non-idle state, so the port is glitch-free
    reg           busy_ff;
    reg  [2:0]    state_ff;
    reg           div_go_ff;
    reg  [W-1:0]  div_a_ff;
    reg  [W-1:0]  div_b_ff;
    reg  [W-1:0]  ratio_i_ff;
    reg  [W-1:0]  ki_ff;
    reg  [W-1:0]  kd_ff;
    reg  [W-1:0]  err_ff;
    reg  [W-1:0]  dpv_ff;
    reg  [TW-1:0] mp_ff;
    reg  [TW-1:0] mi_ff;
    reg  [TW-1:0] md_ff;

    wire          div_done;
    wire [W-1:0]  div_q;
    wire          idle     = (state_ff == ST_IDLE);
    wire [W-1:0]  gain_eff = (gain_ff == `PLU_ZERO) ? `PLU_ONE : gain_ff;
    wire [TW-1:0] pd_sum   = mp_ff + md_ff;
    wire [TW-1:0] m_sum    = mp_ff + mi_ff + md_ff;
    // Out-of-range output backs the bias off so recovery starts at once
    wire          over_one   = !m_sum[TW-1] && (m_sum > sext(`PLU_ONE));
    wire          under_zero = m_sum[TW-1];

    assign process_value          = pv_ff;
    assign setpoint               = sp_ff;
    assign loop_output            = out_ff;
    assign loop_gain              = gain_ff;
    assign sample_period          = ts_ff;
    assign reset_period           = ti_ff;
    assign rate_period            = td_ff;
    assign bias_sum               = bias_ff;
    assign previous_process_value = prev_ff;
    assign history_bit            = hist_ff;
    assign busy                   = busy_ff;
    assign calc_done              = done_ff;

    // ======================================================================
    // Ratio divider, shared by the integral and derivative paths
    plu_div #(
        .W    (W),
        .FRAC (`PLU_FRAC)
    ) u_div (
        .clock    (clock),
        .reset    (reset),
        .start    (div_go_ff),
        .dividend (div_a_ff),
        .divisor  (div_b_ff),
        .done     (div_done),
        .quotient (div_q)
    );

    // ======================================================================
    // Sequencer
    always @(posedge clock) begin
        if (reset) begin
            pv_ff      <= `PLU_RST_VAL;
            sp_ff      <= `PLU_RST_VAL;
            out_ff     <= `PLU_RST_VAL;
            gain_ff    <= `PLU_RST_VAL;
            ts_ff      <= `PLU_RST_VAL;
            ti_ff      <= `PLU_RST_VAL;
            td_ff      <= `PLU_RST_VAL;
            bias_ff    <= `PLU_RST_VAL;
            prev_ff    <= `PLU_RST_VAL;
            hist_ff    <= 1'b1; // R18
            first_ff   <= 1'b1;
            bump_ff    <= 1'b0;
            done_ff    <= 1'b0;
            busy_ff    <= 1'b0;
            state_ff   <= ST_IDLE;
            div_go_ff  <= 1'b0;
            div_a_ff   <= `PLU_RST_VAL;
            div_b_ff   <= `PLU_RST_VAL;
            ratio_i_ff <= `PLU_RST_VAL;
            ki_ff      <= `PLU_RST_VAL;
            kd_ff      <= `PLU_RST_VAL;
            err_ff     <= `PLU_RST_VAL;
            dpv_ff     <= `PLU_RST_VAL;
            mp_ff      <= {TW{1'b0}};
            mi_ff      <= {TW{1'b0}};
            md_ff      <= {TW{1'b0}};
        end else begin
            done_ff   <= 1'b0;
            div_go_ff <= 1'b0;
            // Table writes only land between calculations, so a calculation sees a stable table
            if (tbl_wr && idle) begin
                case (tbl_idx)
                    `PLU_IDX_PV:   pv_ff   <= tbl_wdata;
                    `PLU_IDX_SP:   sp_ff   <= tbl_wdata;
                    `PLU_IDX_OUT:  out_ff  <= tbl_wdata;
                    `PLU_IDX_GAIN: gain_ff <= tbl_wdata;
                    `PLU_IDX_TS:   ts_ff   <= tbl_wdata;
                    `PLU_IDX_TI:   ti_ff   <= tbl_wdata;
                    `PLU_IDX_TD:   td_ff   <= tbl_wdata;
                    `PLU_IDX_BIAS: bias_ff <= tbl_wdata;
                    `PLU_IDX_PREV: prev_ff <= tbl_wdata;
                    default:       pv_ff   <= pv_ff;
                endcase
            end

            case (state_ff)
                ST_IDLE: begin
                    // Run entry wins over a same-cycle evaluate
                    if (run_entry) begin
                        hist_ff  <= 1'b1; // R18
                        first_ff <= 1'b1;
                    end else if (evaluate) begin
                        hist_ff <= enable; // R15
                        bump_ff <= enable && !hist_ff; // R15
                        if (enable) begin
                            state_ff <= ST_INIT; // R14
                            busy_ff  <= 1'b1; // R14
                        end
                    end
                end

                ST_INIT: begin
                    if (bump_ff) begin
                        sp_ff   <= pv_ff; // R16
                        prev_ff <= pv_ff; // R16
                        bias_ff <= out_ff; // R16
                    end else if (first_ff) begin
                        prev_ff <= pv_ff; // R21
                    end
                    div_a_ff  <= ts_ff;
                    div_b_ff  <= ti_ff;
                    div_go_ff <= 1'b1;
                    state_ff  <= ST_DIVI;
                end

                ST_DIVI: begin
                    if (div_done) begin
                        ratio_i_ff <= div_q;
                        div_a_ff   <= td_ff;
                        div_b_ff   <= ts_ff;
                        div_go_ff  <= 1'b1;
                        state_ff   <= ST_DIVD;
                    end
                end

                ST_DIVD: begin
                    if (div_done) begin
                        // Signed ratios carry the time signs into the terms when gain is zero
                        ki_ff    <= fmul(gain_eff, ratio_i_ff); // R22 R6
                        kd_ff    <= fmul(gain_eff, div_q); // R22 R6
                        err_ff   <= sp_ff - pv_ff; // R7
                        dpv_ff   <= prev_ff - pv_ff; // R20
                        state_ff <= ST_COEF;
                    end
                end

                ST_COEF: begin
                    mp_ff    <= sext(fmul(gain_ff, err_ff)); // R5
                    mi_ff    <= sext(fmul(ki_ff, err_ff)) + sext(bias_ff); // R19
                    md_ff    <= sext(fmul(kd_ff, dpv_ff)); // R20
                    state_ff <= ST_TERM;
                end

                ST_TERM: begin
                    // Spare cycle only; the wide three-way add still feeds the clamp combinationally in ST_SUM
                    state_ff <= ST_SUM;
                end

                ST_SUM: begin
                    out_ff <= clamp01(m_sum); // R23 R8
                    if (over_one)
                        bias_ff <= clamp01(sext(`PLU_ONE) - pd_sum); // R10 R11
                    else if (under_zero)
                        bias_ff <= clamp01({TW{1'b0}} - pd_sum); // R10 R11
                    else
                        bias_ff <= clamp01(mi_ff); // R9 R11
                    // Writes are refused while busy, so this is the value the terms used
                    prev_ff  <= pv_ff; // R13
                    first_ff <= 1'b0;
                    done_ff  <= 1'b1;
                    busy_ff  <= 1'b0;
                    state_ff <= ST_IDLE;
                end

                default: begin
                    busy_ff  <= 1'b0;
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- design/plu_defines.vh ----
`ifndef PLU_DEFINES_VH
`define PLU_DEFINES_VH

// ==========================================================================
// Number format: signed fixed point, 16 fraction bits
`define PLU_WIDTH       32
`define PLU_FRAC        16
`define PLU_ONE         32'h00010000
`define PLU_HALF        32'h00008000
`define PLU_ZERO        32'h00000000
`define PLU_RST_VAL     32'h00000000

// ==========================================================================
// Loop table entry indices (byte offset divided by four)
`define PLU_IDX_W       4
`define PLU_IDX_PV      4'h0
`define PLU_IDX_SP      4'h1
`define PLU_IDX_OUT     4'h2
`define PLU_IDX_GAIN    4'h3
`define PLU_IDX_TS      4'h4
`define PLU_IDX_TI      4'h5
`define PLU_IDX_TD      4'h6
`define PLU_IDX_BIAS    4'h7
`define PLU_IDX_PREV    4'h8

// ==========================================================================
// Conditioning spans used by software around the loop
`define PLU_SPAN_UNI    32000
`define PLU_SPAN_BI     64000

`endif

// ---- design/plu_div.v ----
`timescale 1ns/1ps

// ==========================================================================
// Signed fixed-point divider, one quotient bit per clock
module plu_div #(
    parameter W    = 32,
    parameter FRAC = 16
) (
    input  wire         clock,
    input  wire         reset,
    input  wire         start,
    input  wire [W-1:0] dividend,
    input  wire [W-1:0] divisor,
    output wire         done,
    output wire [W-1:0] quotient
);
    localparam DW = W + FRAC;
    localparam CW = $clog2(DW + 1);

    reg  [DW-1:0] num_ff;
    reg  [DW-1:0] quo_ff;
    reg  [W:0]    rem_ff;
    reg  [W-1:0]  den_ff;
    reg  [CW-1:0] cnt_ff;
    reg           neg_ff;
    reg           run_ff;
    reg           done_ff;
    reg  [W-1:0]  res_ff;

    wire [W-1:0]  a_mag = dividend[W-1] ? (~dividend + {{(W-1){1'b0}}, 1'b1}) : dividend;
    wire [W-1:0]  b_mag = divisor[W-1] ? (~divisor + {{(W-1){1'b0}}, 1'b1}) : divisor;
    wire [W:0]    trial = {rem_ff[W-1:0], num_ff[DW-1]};
    wire          fits  = (trial >= {1'b0, den_ff});
    // Zero divisor or oversize result saturates, so a zero ti, or a zero ts in the rate ratio, gives a full-scale ratio
    wire          ovf   = (den_ff == {W{1'b0}}) || (|quo_ff[DW-1:W-1]);
    wire [W-1:0]  mag   = ovf ? {1'b0, {(W-1){1'b1}}} : quo_ff[W-1:0];

    assign done     = done_ff;
    assign quotient = res_ff;

    always @(posedge clock) begin
        if (reset) begin
            num_ff  <= {DW{1'b0}};
            quo_ff  <= {DW{1'b0}};
            rem_ff  <= {(W+1){1'b0}};
            den_ff  <= {W{1'b0}};
            cnt_ff  <= {CW{1'b0}};
            neg_ff  <= 1'b0;
            run_ff  <= 1'b0;
            done_ff <= 1'b0;
            res_ff  <= {W{1'b0}};
        end else begin
            done_ff <= 1'b0;
            if (start) begin
                num_ff <= {a_mag, {FRAC{1'b0}}};
                quo_ff <= {DW{1'b0}};
                rem_ff <= {(W+1){1'b0}};
                den_ff <= b_mag;
                cnt_ff <= DW[CW-1:0];
                neg_ff <= dividend[W-1] ^ divisor[W-1];
                run_ff <= 1'b1;
            end else if (run_ff) begin
                if (cnt_ff == {CW{1'b0}}) begin
                    run_ff  <= 1'b0;
                    done_ff <= 1'b1;
                    res_ff  <= neg_ff ? (~mag + {{(W-1){1'b0}}, 1'b1}) : mag;
                end else begin
                    rem_ff <= fits ? (trial - {1'b0, den_ff}) : trial;
                    num_ff <= {num_ff[DW-2:0], 1'b0};
                    quo_ff <= {quo_ff[DW-2:0], fits};
                    cnt_ff <= cnt_ff - {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// ---- tb/plu_core_properties.sv ----
`timescale 1ns/1ps
`include "plu_defines.vh"

// ==========================================================
// Port checker for the loop update unit
module plu_core_properties #(
    parameter W = 32
) (
    input logic                  clock,
    input logic                  reset,
    input logic                  run_entry,
    input logic                  evaluate,
    input logic                  enable,
    input logic                  tbl_wr,
    input logic [`PLU_IDX_W-1:0] tbl_idx,
    input logic [W-1:0]          tbl_wdata,
    input logic [W-1:0]          process_value,
    input logic [W-1:0]          setpoint,
    input logic [W-1:0]          loop_output,
    input logic [W-1:0]          loop_gain,
    input logic [W-1:0]          sample_period,
    input logic [W-1:0]          reset_period,
    input logic [W-1:0]          rate_period,
    input logic [W-1:0]          bias_sum,
    input logic [W-1:0]          previous_process_value,
    input logic                  history_bit,
    input logic                  busy,
    input logic                  calc_done
);
    // Accepted requests, kept as plain signals so $past sees a signal
    wire take    = evaluate && !busy && !run_entry;
    wire wr_pv   = tbl_wr && !busy && tbl_idx == `PLU_IDX_PV;
    wire wr_sp   = tbl_wr && !busy && tbl_idx == `PLU_IDX_SP;
    wire wr_prev = tbl_wr && !busy && tbl_idx == `PLU_IDX_PREV;

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    property p_pv_hold; $changed(process_value) |-> $past(reset) || $past(wr_pv); endproperty
    a_pv_hold: assert property (p_pv_hold) else $error("process value changed by the unit");
    property p_sp_hold; $changed(setpoint) |-> $past(reset) || $past(wr_sp) || $past(busy); endproperty
    a_sp_hold: assert property (p_sp_hold) else $error("setpoint changed outside init");
    property p_prev_hold;
        $changed(previous_process_value) |-> $past(reset) || $past(wr_prev) || $past(busy);
    endproperty
    a_prev_hold: assert property (p_prev_hold) else $error("previous value changed while idle");
    property p_prev_eq; calc_done |-> previous_process_value == process_value; endproperty
    a_prev_eq: assert property (p_prev_eq) else $error("previous value not saved");
    property p_hist; take |=> history_bit == $past(enable); endproperty
    a_hist: assert property (p_hist) else $error("history bit not the sampled enable");
    property p_run; run_entry && !busy |=> history_bit; endproperty
    a_run: assert property (p_run) else $error("history bit not set on run entry");
    property p_manual; take && !enable |=> !busy [*2]; endproperty
    a_manual: assert property (p_manual) else $error("calculation started in manual");
    property p_auto; take && enable |=> busy; endproperty
    a_auto: assert property (p_auto) else $error("calculation not started");
    property p_done; $rose(busy) |-> ##[20:300] calc_done; endproperty
    a_done: assert property (p_done) else $error("calculation never completed");
    property p_out; calc_done |-> !loop_output[W-1] && loop_output <= `PLU_ONE; endproperty
    a_out: assert property (p_out) else $error("output outside zero to one");
    property p_bias; calc_done |-> !bias_sum[W-1] && bias_sum <= `PLU_ONE; endproperty
    a_bias: assert property (p_bias) else $error("bias outside zero to one");
    // Checked three edges on so either init slot is covered; the math is far longer
    property p_bump;
        take && enable && !history_bit |-> ##3 setpoint == process_value && bias_sum == loop_output;
    endproperty
    a_bump: assert property (p_bump) else $error("bumpless init missing");

    c_bump: cover property (take && enable && !history_bit);
    c_high: cover property (calc_done && loop_output == `PLU_ONE);
    c_refused: cover property (evaluate && busy);
endmodule

bind plu_core plu_core_properties #(.W(W)) u_props (
    .clock(clock), .reset(reset), .run_entry(run_entry), .evaluate(evaluate), .enable(enable),
    .tbl_wr(tbl_wr), .tbl_idx(tbl_idx), .tbl_wdata(tbl_wdata), .process_value(process_value),
    .setpoint(setpoint), .loop_output(loop_output), .loop_gain(loop_gain), .sample_period(sample_period),
    .reset_period(reset_period), .rate_period(rate_period), .bias_sum(bias_sum),
    .previous_process_value(previous_process_value), .history_bit(history_bit), .busy(busy),
    .calc_done(calc_done)
);

// ---- tb/plu_tb.sv ----
`timescale 1ns/1ps
`include "plu_defines.vh"

module tb;
    // ==========================================================
    // Stimulus and observed ports
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        run_entry = 1'b0;
    logic        evaluate = 1'b0;
    logic        enable = 1'b0;
    logic        tbl_wr = 1'b0;
    logic [3:0]  tbl_idx = 4'h0;
    logic [31:0] tbl_wdata = 32'h00000000;
    wire  [31:0] ent [0:8];
    wire         history_bit;
    wire         busy;
    wire         calc_done;
    int          fail_count = 0;
    int          cmp_count = 0;
    logic [31:0] rows [0:6][0:10];
    logic [31:0] setup [0:8];

    always #5 clock = ~clock;

    plu_core u_dut (
        .clock(clock), .reset(reset), .run_entry(run_entry), .evaluate(evaluate), .enable(enable),
        .tbl_wr(tbl_wr), .tbl_idx(tbl_idx), .tbl_wdata(tbl_wdata), .process_value(ent[0]),
        .setpoint(ent[1]), .loop_output(ent[2]), .loop_gain(ent[3]), .sample_period(ent[4]),
        .reset_period(ent[5]), .rate_period(ent[6]), .bias_sum(ent[7]),
        .previous_process_value(ent[8]), .history_bit(history_bit), .busy(busy), .calc_done(calc_done)
    );

    // ==========================================================
    // Shared tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] idx, input logic [31:0] data);
        @(negedge clock);
        tbl_wr = 1'b1;
        tbl_idx = idx;
        tbl_wdata = data;
        @(negedge clock);
        tbl_wr = 1'b0;
    endtask

    task automatic load();
        for (int i = 0; i < 9; i++) wr(4'(i), setup[i]);
    endtask

    task automatic start_eval(input logic en);
        @(negedge clock);
        evaluate = 1'b1;
        enable = en;
        @(negedge clock);
        evaluate = 1'b0;
    endtask

    // Latency is fixed but not promised, so wait on the pulse with a bound
    task automatic wait_done();
        int n;
        n = 0;
        while (calc_done !== 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
        end
        check("calc_done", 32'(calc_done), 32'h00000001);
        @(negedge clock);
    endtask

    // Software conditioning around the loop: raw counts in, analog counts out
    function automatic logic [31:0] norm(input int raw, input int span, input logic bipolar);
        norm = 32'((longint'(raw) <<< 16) / span) + (bipolar ? 32'h00008000 : 32'h00000000);
    endfunction

    function automatic logic [15:0] to_analog(input logic [31:0] m, input int span, input logic bipolar);
        longint scal;
        scal = ((longint'($signed(m)) - (bipolar ? 64'sh8000 : 64'sh0)) * span) / 65536;
        to_analog = scal[15:0];
    endfunction

    task automatic test_done();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fail_count++;
        test_done();
    end

    // ==========================================================
    // Main sequence: pv sp out gain ts ti td bias prev | out bias
    initial begin
        rows = '{'{32'h8000, 32'hC000, 32'h0, 32'h10000, 32'h10000, 32'h10000, 32'h0, 32'h4000, 32'h8000,
                   32'hC000, 32'h8000},
                 '{32'h8000, 32'h4000, 32'h0, 32'hFFFF0000, 32'h10000, 32'h10000, 32'h0, 32'h4000, 32'h8000,
                   32'hC000, 32'h8000},
                 '{32'h0, 32'h10000, 32'h0, 32'h10000, 32'h10000, 32'h10000, 32'h0, 32'h8000, 32'h0,
                   32'h10000, 32'h0},
                 '{32'h10000, 32'h0, 32'h0, 32'h10000, 32'h10000, 32'h10000, 32'h0, 32'h8000, 32'h10000,
                   32'h0, 32'h10000},
                 '{32'h4000, 32'h8000, 32'h0, 32'h0, 32'h10000, 32'h20000, 32'h10000, 32'h4000, 32'h8000,
                   32'hA000, 32'h6000},
                 '{32'h4000, 32'h8000, 32'h0, 32'h0, 32'h10000, 32'hFFFF0000, 32'hFFFF0000, 32'h8000,
                   32'h6000, 32'h2000, 32'h4000},
                 '{32'h8000, 32'h0, 32'h0, 32'h10000, 32'h10000, 32'hFFFF0000, 32'h0, 32'h10000, 32'h8000,
                   32'h10000, 32'h10000}};
        repeat (6) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        for (int i = 0; i < 9; i++) check("table entry", ent[i], 32'h00000000);
        check("history_bit", 32'(history_bit), 32'h00000001);
        // First sample ignores the stale previous value
        setup = '{32'h8000, 32'h8000, 32'h0, 32'h10000, 32'h10000, 32'h10000, 32'h10000, 32'h4000, 32'h10000};
        setup[0] = norm(16000, `PLU_SPAN_UNI, 1'b0);
        load();
        start_eval(1'b1);
        wait_done();
        check("loop_output", ent[2], 32'h00004000);
        check("analog_out", 32'(to_analog(ent[2], `PLU_SPAN_UNI, 1'b0)), 32'h00001F40);
        check("bipolar_in", norm(-16000, `PLU_SPAN_BI, 1'b1), 32'h00004000);
        for (int r = 0; r < 7; r++) begin
            for (int i = 0; i < 9; i++) wr(4'(i), rows[r][i]);
            start_eval(1'b1);
            wait_done();
            check("loop_output", ent[2], rows[r][9]);
            check("bias_sum", ent[7], rows[r][10]);
            for (int i = 0; i < 7; i++)
                if (i != 2) check("table entry", ent[i], rows[r][i]);
        end
        // Manual then bumpless return to auto
        start_eval(1'b0);
        check("history_bit", 32'(history_bit), 32'h00000000);
        check("busy", 32'(busy), 32'h00000000);
        check("loop_output", ent[2], rows[6][9]);
        setup = '{32'h5000, 32'hF000, 32'h6000, 32'h10000, 32'h10000, 32'h10000, 32'h10000, 32'h0, 32'h0};
        load();
        start_eval(1'b1);
        wait_done();
        check("setpoint", ent[1], 32'h00005000);
        check("previous_process_value", ent[8], 32'h00005000);
        check("bias_sum", ent[7], 32'h00006000);
        check("loop_output", ent[2], 32'h00006000);
        check("analog_out", 32'(to_analog(ent[2], `PLU_SPAN_BI, 1'b1)), 32'h0000E0C0);
        // Write and evaluate while busy are both dropped
        start_eval(1'b1);
        @(negedge clock);
        tbl_wr = 1'b1;
        tbl_idx = 4'h0;
        tbl_wdata = 32'h00001234;
        evaluate = 1'b1;
        enable = 1'b0;
        @(negedge clock);
        tbl_wr = 1'b0;
        evaluate = 1'b0;
        wait_done();
        check("process_value", ent[0], 32'h00005000);
        check("history_bit", 32'(history_bit), 32'h00000001);
        // Run entry sets the history bit, so no init follows
        start_eval(1'b0);
        @(negedge clock);
        run_entry = 1'b1;
        @(negedge clock);
        run_entry = 1'b0;
        check("history_bit", 32'(history_bit), 32'h00000001);
        wr(4'h1, 32'h0000C000);
        start_eval(1'b1);
        wait_done();
        check("setpoint", ent[1], 32'h0000C000);
        // Reset in mid calculation
        start_eval(1'b1);
        repeat (5) @(negedge clock);
        reset = 1'b1;
        repeat (2) @(negedge clock);
        reset = 1'b0;
        check("busy", 32'(busy), 32'h00000000);
        check("history_bit", 32'(history_bit), 32'h00000001);
        check("loop_output", ent[2], 32'h00000000);
        test_done();
    end
endmodule
